/* File: src/nco_defs.svh */
`ifndef NCO_DEFS_SVH
`define NCO_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define NCO_OFS_FREQ_A     8'h00
`define NCO_OFS_FREQ_B     8'h04
`define NCO_OFS_PHASE0     8'h08
`define NCO_OFS_PHASE1     8'h0C
`define NCO_OFS_PHASE2     8'h10
`define NCO_OFS_PHASE3     8'h14
`define NCO_OFS_CTRL       8'h18
`define NCO_OFS_ACC        8'h1C
`define NCO_OFS_SAMPLE     8'h20

// ----------------------------------------------------------------------
// Control field positions and reset value
// ----------------------------------------------------------------------
`define NCO_CTRL_SRC_BIT   0
`define NCO_CTRL_FSEL_BIT  1
`define NCO_CTRL_PSEL_LO   2
`define NCO_CTRL_PSEL_HI   3
`define NCO_CTRL_HOLD_BIT  4
`define NCO_CTRL_CLR_BIT   5
`define NCO_CTRL_RESET     5'h10

// ----------------------------------------------------------------------
// Datapath widths, FIFO depth and cosine table constants
// ----------------------------------------------------------------------
`define NCO_ACC_W          32
`define NCO_PHASE_W        12
`define NCO_AMP_W          10
`define NCO_FIFO_DEPTH     8
`define NCO_Q28_ONE        64'h0000_0000_1000_0000
`define NCO_Q28_HALF       64'h0000_0000_0800_0000
`define NCO_HALF_PI_Q28    64'h0000_0000_1921_FB54
`define NCO_AMP_HALF       511

`endif

/* File: src/nco_pkg.sv */
`default_nettype none
`include "nco_defs.svh"

package nco_pkg;

    // Selection and hold state written by software
    typedef struct packed {
        logic       hold_reset;
        logic [1:0] phase_pick;
        logic       freq_pick;
        logic       choice_source;
    } nco_ctl_type;

    // One amplitude code on its way to the converter
    typedef struct packed {
        logic [`NCO_AMP_W-1:0] code;
    } nco_sample_type;

endpackage : nco_pkg
`default_nettype wire

/* File: src/nco_phase_accumulator_lut.sv */
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "nco_defs.svh"

// ----------------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------------
module nco_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    nxt_wr_ptr;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW-1:0]    nxt_rd_ptr;
    logic [PW:0]      count_ff;
    logic [PW:0]      nxt_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != (PW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
    endfunction : ptr_inc

    always_comb begin
        nxt_wr_ptr = push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
        nxt_rd_ptr = pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
        nxt_count  = count_ff;
        if (push && !pop) begin
            nxt_count = (PW+1)'(count_ff + 1'b1);
        end else if (pop && !push) begin
            nxt_count = (PW+1)'(count_ff - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff  <= nxt_count;
        end
    end

    // Storage needs no reset; nothing is read before it is written
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end
endmodule : nco_fifo

// ----------------------------------------------------------------------
// Oscillator core
// ----------------------------------------------------------------------
module nco_phase_accumulator_lut #(
    parameter int ACC_W  = `NCO_ACC_W,
    parameter int FIFO_D = `NCO_FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        freq_choice_line,
    input  wire logic        phase_choice_bit0,
    input  wire logic        phase_choice_bit1,
    output logic             dac_valid,
    input  wire logic        dac_ready,
    output logic      [9:0]  dac_code
);
    import nco_pkg::*;

    localparam int PW = `NCO_PHASE_W;
    localparam int AW = `NCO_AMP_W;

    // ------------------------------------------------------------------
    // Quarter-wave cosine table
    // ------------------------------------------------------------------
    // Horner form of the Taylor series in Q28; error stays far below one
    // code step over a quarter turn, so no table file is needed.
    function automatic logic [AW-2:0] quarter_cos(input int idx);
        longint x;
        longint x2;
        longint t;
        x  = (longint'(idx) * longint'(`NCO_HALF_PI_Q28)) >>> (PW - 2);
        x2 = (x * x) >>> 28;
        t  = longint'(`NCO_Q28_ONE) - x2 / 56;
        t  = longint'(`NCO_Q28_ONE) - ((x2 * t) >>> 28) / 30;
        t  = longint'(`NCO_Q28_ONE) - ((x2 * t) >>> 28) / 12;
        t  = longint'(`NCO_Q28_ONE) - ((x2 * t) >>> 28) / 2;
        if (t < 0) begin
            t = 0;
        end
        quarter_cos = (AW-1)'((t * `NCO_AMP_HALF + longint'(`NCO_Q28_HALF)) >>> 28);
    endfunction : quarter_cos

    logic [AW-2:0] qrom [2**(PW-2)];

    for (genvar g = 0; g < 2**(PW-2); g++) begin : g_rom
        assign qrom[g] = quarter_cos(g);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [ACC_W-1:0] freq_a_ff;
    logic [ACC_W-1:0] nxt_freq_a;
    logic [ACC_W-1:0] freq_b_ff;
    logic [ACC_W-1:0] nxt_freq_b;
    logic [PW-1:0]    phase_ff [4];
    logic [PW-1:0]    nxt_phase [4];
    nco_ctl_type      ctl_ff;
    nco_ctl_type      nxt_ctl;
    logic [31:0]      rdata_ff;
    logic [31:0]      nxt_rdata;
    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] nxt_acc;
    nco_sample_type   sample_ff;
    nco_sample_type   nxt_sample;
    logic             sample_vld_ff;

    logic             freq_sel;
    logic [1:0]       phase_sel;
    logic [ACC_W-1:0] step;
    logic [PW-1:0]    phase_addr;
    logic [PW-3:0]    q_idx;
    logic [AW-2:0]    q_val;
    logic [AW-1:0]    amp;
    logic             advance;

    always_comb begin
        nxt_freq_a = freq_a_ff;
        nxt_freq_b = freq_b_ff;
        nxt_ctl    = ctl_ff;
        for (int i = 0; i < 4; i++) begin
            nxt_phase[i] = phase_ff[i];
        end
        if (reg_wr) begin
            case (reg_addr)
                `NCO_OFS_FREQ_A: nxt_freq_a = reg_wdata[ACC_W-1:0];
                `NCO_OFS_FREQ_B: nxt_freq_b = reg_wdata[ACC_W-1:0];
                `NCO_OFS_PHASE0: nxt_phase[0] = reg_wdata[PW-1:0];
                `NCO_OFS_PHASE1: nxt_phase[1] = reg_wdata[PW-1:0];
                `NCO_OFS_PHASE2: nxt_phase[2] = reg_wdata[PW-1:0];
                `NCO_OFS_PHASE3: nxt_phase[3] = reg_wdata[PW-1:0];
                `NCO_OFS_CTRL: begin
                    nxt_ctl.choice_source = reg_wdata[`NCO_CTRL_SRC_BIT];
                    nxt_ctl.freq_pick     = reg_wdata[`NCO_CTRL_FSEL_BIT];
                    nxt_ctl.phase_pick    = reg_wdata[`NCO_CTRL_PSEL_HI:`NCO_CTRL_PSEL_LO];
                    nxt_ctl.hold_reset    = reg_wdata[`NCO_CTRL_HOLD_BIT];
                    // Clear forces the line inputs back in charge
                    if (reg_wdata[`NCO_CTRL_CLR_BIT]) begin
                        nxt_ctl.choice_source = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `NCO_OFS_FREQ_A: nxt_rdata = 32'(freq_a_ff);
                `NCO_OFS_FREQ_B: nxt_rdata = 32'(freq_b_ff);
                `NCO_OFS_PHASE0: nxt_rdata = 32'(phase_ff[0]);
                `NCO_OFS_PHASE1: nxt_rdata = 32'(phase_ff[1]);
                `NCO_OFS_PHASE2: nxt_rdata = 32'(phase_ff[2]);
                `NCO_OFS_PHASE3: nxt_rdata = 32'(phase_ff[3]);
                `NCO_OFS_CTRL:   nxt_rdata = 32'(ctl_ff);
                `NCO_OFS_ACC:    nxt_rdata = 32'(acc_ff);
                `NCO_OFS_SAMPLE: nxt_rdata = 32'(sample_ff.code);
                default:         nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Phase path
    // ------------------------------------------------------------------
    always_comb begin
        freq_sel  = ctl_ff.choice_source ? ctl_ff.freq_pick : freq_choice_line;
        phase_sel = ctl_ff.choice_source ? ctl_ff.phase_pick
                                         : {phase_choice_bit1, phase_choice_bit0};
        step      = freq_sel ? freq_b_ff : freq_a_ff;
        // Top bits plus offset, wrapping in 12 bits, then used as the address
        phase_addr = PW'(acc_ff[ACC_W-1 -: PW] + phase_ff[phase_sel]);
        // Mirror the index in quadrants 1 and 3 to reuse the quarter table
        q_idx = phase_addr[PW-2] ? ~phase_addr[PW-3:0] : phase_addr[PW-3:0];
        q_val = qrom[q_idx];
        case (phase_addr[PW-1:PW-2])
            2'b00:   amp = {1'b1, q_val};
            2'b11:   amp = {1'b1, q_val};
            default: amp = {1'b0, ~q_val};
        endcase
        nxt_sample = sample_ff;
        nxt_acc    = acc_ff;
        if (advance) begin
            nxt_sample.code = amp;
            // Selection changes only swap the step, never the running sum
            nxt_acc = ACC_W'(acc_ff + step);
        end
        // Hold wins over any step, stalled or not
        if (ctl_ff.hold_reset) begin
            nxt_acc = '0;
        end
    end

    // A full FIFO stalls the whole phase path rather than drop codes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_a_ff     <= '0;
            freq_b_ff     <= '0;
            for (int i = 0; i < 4; i++) begin
                phase_ff[i] <= '0;
            end
            ctl_ff        <= nco_ctl_type'(`NCO_CTRL_RESET);
            rdata_ff      <= 32'h0000_0000;
            acc_ff        <= '0;
            sample_ff     <= '0;
            sample_vld_ff <= 1'b0;
        end else begin
            freq_a_ff     <= nxt_freq_a;
            freq_b_ff     <= nxt_freq_b;
            for (int i = 0; i < 4; i++) begin
                phase_ff[i] <= nxt_phase[i];
            end
            ctl_ff        <= nxt_ctl;
            rdata_ff      <= nxt_rdata;
            acc_ff        <= nxt_acc;
            sample_ff     <= nxt_sample;
            sample_vld_ff <= 1'b1;
        end
    end

    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------------
    // Converter buffer
    // ------------------------------------------------------------------
    logic fifo_in_ready;

    // Before the first sample exists the path runs free; afterwards it
    // advances only when the buffer takes the code just made, so the
    // accumulator and the code stream never drift apart
    assign advance = fifo_in_ready || !sample_vld_ff;

    nco_fifo #(
        .WIDTH (AW),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (sample_vld_ff),
        .in_ready  (fifo_in_ready),
        .in_data   (sample_ff.code),
        .out_valid (dac_valid),
        .out_ready (dac_ready),
        .out_data  (dac_code)
    );
endmodule : nco_phase_accumulator_lut
`default_nettype wire

/* File: dv/nco_phase_accumulator_lut_props.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module nco_phase_accumulator_lut_props #(
    parameter int ACC_W  = 32,
    parameter int FIFO_D = 8
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        freq_choice_line,
    input wire logic        phase_choice_bit0,
    input wire logic        phase_choice_bit1,
    input wire logic        dac_valid,
    input wire logic        dac_ready,
    input wire logic [9:0]  dac_code
);
    import nco_pkg::*;
    logic [31:0] fa_ff, fb_ff, step;
    logic        src_ff, fbit_ff, hold_ff;
    // Shadow of software state, so the expected step is known at the ports
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {fa_ff, fb_ff, src_ff, fbit_ff, hold_ff} <= {64'h0, 3'h1};
        end else if (reg_wr) begin
            if (reg_addr == 8'h00) fa_ff <= reg_wdata;
            if (reg_addr == 8'h04) fb_ff <= reg_wdata;
            if (reg_addr == 8'h18) begin
                {fbit_ff, hold_ff} <= {reg_wdata[1], reg_wdata[4]};
                src_ff <= reg_wdata[0] & ~reg_wdata[5];
            end
        end
    end
    assign step = (src_ff ? fbit_ff : freq_choice_line) ? fb_ff : fa_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_acc_rd;
        reg_rd && reg_addr == 8'h1C && dac_ready && !hold_ff;
    endsequence
    // Ready a cycle early keeps the FIFO off full, so no stall hides a step
    sequence s_two_rd;
        dac_ready ##1 s_acc_rd ##1 (reg_rd && reg_addr == 8'h1C && dac_ready && $stable(step));
    endsequence
    a_acc_step: assert property (s_two_rd |=> reg_rdata - $past(reg_rdata) == $past(step))
        else $error("accumulator step wrong");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_hold_zero: assert property (reg_rd && reg_addr == 8'h1C && hold_ff && $past(hold_ff) |=> reg_rdata == 32'h0)
        else $error("accumulator moved under hold");
    a_freq_back: assert property (reg_wr && reg_addr == 8'h04 ##1 reg_rd && reg_addr == 8'h04 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("second frequency word lost");
    a_code_holds: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_code))
        else $error("code changed before taken");
    a_valid_soon: assert property (dac_ready && !dac_valid |-> ##[1:4] dac_valid)
        else $error("no code offered");
    a_ctrl_bits: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata[31:5] == 27'h0)
        else $error("control reads stray bits");
    a_phase_width: assert property (reg_rd && reg_addr inside {8'h08, 8'h0C, 8'h10, 8'h14}
        |=> reg_rdata[31:12] == 20'h0)
        else $error("offset wider than 12 bits");
endmodule : nco_phase_accumulator_lut_props
bind nco_phase_accumulator_lut nco_phase_accumulator_lut_props #(.ACC_W(ACC_W), .FIFO_D(FIFO_D))
    u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .freq_choice_line(freq_choice_line),
    .phase_choice_bit0(phase_choice_bit0), .phase_choice_bit1(phase_choice_bit1),
    .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_code(dac_code));
`default_nettype wire

/* File: dv/nco_dac_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Converter model: prompt, stalled or random take
// ----------------------------------------
module nco_dac_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] mode,
    input  wire logic       dac_valid,
    input  wire logic [9:0] dac_code,
    output logic            dac_ready,
    output logic      [9:0] last_code
);
    logic [31:0] lfsr_ff, nxt_lfsr, t;
    logic        ready_ff, nxt_ready;
    logic [9:0]  code_ff, nxt_code;
    always_comb begin
        t = lfsr_ff ^ (lfsr_ff << 13);
        t = t ^ (t >> 17);
        nxt_lfsr = t ^ (t << 5);
        nxt_ready = (mode == 2'h0) | ((mode == 2'h2) & nxt_lfsr[0]);
        nxt_code = (dac_valid && dac_ready) ? dac_code : code_ff;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {lfsr_ff, ready_ff, code_ff} <= {32'h2, 11'h0};
        end else begin
            {lfsr_ff, ready_ff, code_ff} <= {nxt_lfsr, nxt_ready, nxt_code};
        end
    end
    assign dac_ready = ready_ff;
    assign last_code = code_ff;
endmodule : nco_dac_model
`default_nettype wire

/* File: dv/nco_phase_accumulator_lut_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module nco_phase_accumulator_lut_tb;
    import nco_pkg::*;
    logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, line = 0, pb0 = 0, pb1 = 0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, smp, seed = 32'h2, d0, d1, fa, fb;
    logic [1:0]  mode = 2'h0;
    logic        dac_valid, dac_ready;
    logic [9:0]  dac_code, last_code;
    int          err_total = 0, samples_checked = 0;
    always #2 clk = ~clk;
    nco_phase_accumulator_lut u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .freq_choice_line(line), .phase_choice_bit0(pb0), .phase_choice_bit1(pb1),
        .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_code(dac_code));
    nco_dac_model u_dac (.clk(clk), .rst_n(rst_n), .mode(mode), .dac_valid(dac_valid),
        .dac_code(dac_code), .dac_ready(dac_ready), .last_code(last_code));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // One bus slot; smp holds the read data of the slot two calls back
    task automatic bus(input logic r, input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        smp = reg_rdata;
        {reg_rd, reg_wr, reg_addr, reg_wdata} <= {r, w, a, d};
    endtask : bus
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1, 0, a, 32'h0);
        bus(0, 0, 8'h0, 32'h0);
        bus(0, 0, 8'h0, 32'h0);
        d = smp;
    endtask : rd
    task automatic acc2(output logic [31:0] diff);
        bus(1, 0, 8'h1C, 32'h0);
        bus(1, 0, 8'h1C, 32'h0);
        bus(0, 0, 8'h0, 32'h0);
        d0 = smp;
        bus(0, 0, 8'h0, 32'h0);
        diff = smp - d0;
    endtask : acc2
    task automatic settle();
        repeat (14) bus(0, 0, 8'h0, 32'h0);
    endtask : settle
    task automatic give_verdict();
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #40000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h18, d1); `CHK(d1, 32'h10)
        rd(8'hFC, d1); `CHK(d1, 32'h0)
        rd(8'h1C, d1); `CHK(d1, 32'h0)
        settle(); `CHK(last_code, 10'h3FF)
        rd(8'h20, d1); `CHK(d1, 32'h3FF)
        bus(0, 1, 8'h10, 32'hFFFF_F800);
        bus(1, 0, 8'h10, 32'h0);
        bus(0, 0, 8'h0, 32'h0);
        bus(0, 0, 8'h0, 32'h0); `CHK(smp, 32'h800)
        {pb1, pb0} <= 2'h2;
        settle(); `CHK(last_code, 10'h0)
        bus(0, 1, 8'h18, 32'h15);
        settle(); `CHK(last_code, 10'h3FF)
        bus(0, 1, 8'h18, 32'h35);
        settle(); `CHK(last_code, 10'h0)
        for (int i = 0; i < 4; i++) begin
            fa = (i == 0) ? 32'hFFFF_FFFF : xs();
            fb = xs();
            bus(0, 1, 8'h00, fa);
            bus(0, 1, 8'h04, fb);
            rd(8'h04, d0); `CHK(d0, fb)
            rd(8'h00, d0); `CHK(d0, fa)
            bus(0, 1, 8'h18, 32'h0);
            line <= 1'b0;
            acc2(d1); `CHK(d1, fa)
            line <= 1'b1;
            acc2(d1); `CHK(d1, fb)
            bus(0, 1, 8'h18, 32'h3);
            line <= 1'b0;
            acc2(d1); `CHK(d1, fb)
            bus(0, 1, 8'h18, 32'h23);
            acc2(d1); `CHK(d1, fa)
        end
        mode <= 2'h1;
        repeat (20) bus(0, 0, 8'h0, 32'h0);
        acc2(d1); `CHK(d1, 32'h0)
        mode <= 2'h2;
        repeat (60) bus(0, 0, 8'h0, 32'h0);
        mode <= 2'h0;
        {pb1, pb0} <= 2'h0;
        bus(0, 1, 8'h18, 32'h10);
        settle(); `CHK({dac_valid, last_code}, 11'h7FF)
        rd(8'h1C, d1); `CHK(d1, 32'h0)
        give_verdict();
    end
endmodule : nco_phase_accumulator_lut_tb
`undef CHK
`default_nettype wire
